// ---- design/wdt_feed_top.sv ----
// Watchdog timer with keyed feed, reset pulse and interval mode
//
// Behaviour
// - With the fuse set the counter advances only on the independent RC oscillator.
// - With the fuse set a missed feed resets the CPU and software cannot stop the count.
// - With the fuse clear the counter is an interval timer that raises an interrupt.
// - A three-bit select picks one of eight reload values, each twice the previous one.
// - With the fuse set the control register takes one write only after reset.
// - With the fuse or the clock bit set the count keeps running on its own clock when the CPU oscillator stops.
// - A chip reset from any other source holds the counter idle while it lasts.
// - Writing 1Eh then E1h to the feed key register is the only way to restart.
// - The two key writes may be separated by any activity other than a feed key register write.
// - A wrong key leaves the schedule untouched and simply drops the first key.
// - A timeout reset is held for about one microsecond, then execution resumes.
// - A timeout in power down starts the oscillator and holds execution until stable.
// - After a non-watchdog reset the control register reads 10h fused, else 00h.
`timescale 1ns/1ns
module wdt_feed_top
   import wdt_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter logic [23:0] TICK_BASE = 24'h004000,
   parameter logic [15:0] CPU_DIV = 16'h00fa
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Configuration and chip status
   input wire logic watchdog_enable_fuse_i,
   input wire logic rc_osc_i,
   input wire logic power_down_i,
   input wire logic osc_stable_i,
   // Software writes
   input wire wdt_wr_t ctrl_wr_i,
   input wire wdt_wr_t feed_wr_i,
   // Software read of the control register
   output logic [7:0] watchdog_control_reg_o,
   // Chip effects
   output logic wdt_reset_o,
   output logic irq_o,
   output logic osc_start_o,
   output logic exec_hold_o
);

   localparam logic [7:0] RST_CYC = 8'(RST_PULSE_CYC);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic rc_tick;
   logic osc_stable_s;

   wdt_tick_sync u_rc_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(rc_osc_i),
      .level_o(),
      .rise_o(rc_tick)
   );

   wdt_tick_sync u_stable_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(osc_stable_i),
      .level_o(osc_stable_s),
      .rise_o()
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] div_q, div_d;
   logic [2:0] sel_q, sel_d;
   logic run_q, run_d;
   logic clk_q, clk_d;
   logic ovf_q, ovf_d;
   logic written_q, written_d;
   logic armed_q, armed_d;
   logic [7:0] pulse_q, pulse_d;
   wdt_state_t state_q, state_d;

   logic fuse;
   logic cpu_tick;
   logic tick;
   logic running;
   logic feed_ok;
   logic expire;
   logic [CNT_W-1:0] load_val;

   assign fuse = watchdog_enable_fuse_i;
   assign cpu_tick = (div_q == 16'h0000);
   // Fuse forces the RC clock so a dead CPU clock still times out
   assign tick = (fuse | clk_q) ? rc_tick : cpu_tick;
   assign running = (fuse | run_q) & (state_q == WDT_RUN);
   assign feed_ok = feed_wr_i.en & (feed_wr_i.data == FEED_KEY_SECOND)
                  & armed_q;
   assign load_val = CNT_W'(TICK_BASE) << sel_q;
   assign expire = running & tick & (cnt_q == '0) & ~feed_ok;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      div_d = (div_q == 16'h0000) ? CPU_DIV : div_q - 16'h0001;
      sel_d = sel_q;
      run_d = run_q;
      clk_d = clk_q;
      ovf_d = ovf_q;
      written_d = written_q;
      armed_d = armed_q;
      pulse_d = pulse_q;
      state_d = state_q;

      // Control writes; the fused part locks after the first one
      if (ctrl_wr_i.en) begin
         if (fuse) begin
            if (!written_q) begin
               sel_d = ctrl_wr_i.data[CTRL_SEL_LSB +: CTRL_SEL_W];
               written_d = 1'b1;
            end
         end else begin
            sel_d = ctrl_wr_i.data[CTRL_SEL_LSB +: CTRL_SEL_W];
            run_d = ctrl_wr_i.data[CTRL_RUN_BIT];
            clk_d = ctrl_wr_i.data[CTRL_CLK_BIT];
            if (!ctrl_wr_i.data[CTRL_OVF_BIT]) begin
               ovf_d = 1'b0;
            end
         end
      end

      // Key sequence; unrelated cycles between keys keep the arm
      if (feed_wr_i.en) begin
         if (feed_wr_i.data == FEED_KEY_FIRST) begin
            armed_d = 1'b1;
         end else begin
            armed_d = 1'b0;
         end
      end
      if (feed_ok) begin
         cnt_d = load_val;
         ovf_d = 1'b0;
      end else if (running & tick) begin
         if (cnt_q == '0) begin
            cnt_d = load_val;
         end else begin
            cnt_d = cnt_q - CNT_W'(1);
         end
      end

      // Set wins over any clear in the same cycle
      if (expire) begin
         ovf_d = 1'b1;
      end

      unique case (state_q)
         WDT_RUN: begin
            if (expire & fuse) begin
               state_d = WDT_RST;
               pulse_d = RST_CYC - 8'h01;
               written_d = 1'b0;
               armed_d = 1'b0;
            end
         end
         WDT_RST: begin
            if (pulse_q == 8'h00) begin
               state_d = power_down_i ? WDT_OSC : WDT_RUN;
               cnt_d = load_val;
            end else begin
               pulse_d = pulse_q - 8'h01;
            end
         end
         WDT_OSC: begin
            if (osc_stable_s) begin
               state_d = WDT_RUN;
            end
         end
         default: begin
            state_d = WDT_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cnt_q <= CNT_W'(TICK_BASE);
         div_q <= CPU_DIV;
         sel_q <= SEL_RST;
         run_q <= CTRL_RST_FUSE_OFF[CTRL_RUN_BIT];
         clk_q <= CTRL_RST_FUSE_OFF[CTRL_CLK_BIT];
         ovf_q <= 1'b0;
         written_q <= 1'b0;
         armed_q <= 1'b0;
         pulse_q <= 8'h00;
         state_q <= WDT_RUN;
      end else begin
         cnt_q <= cnt_d;
         div_q <= div_d;
         sel_q <= sel_d;
         run_q <= run_d;
         clk_q <= clk_d;
         ovf_q <= ovf_d;
         written_q <= written_d;
         armed_q <= armed_d;
         pulse_q <= pulse_d;
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Fused view reads 10h after reset: run forced, clock bit hidden
   always_comb begin
      watchdog_control_reg_o = fuse ? CTRL_RST_FUSE_ON : CTRL_RST_FUSE_OFF;
      watchdog_control_reg_o[CTRL_OVF_BIT] = ovf_q;
      watchdog_control_reg_o[CTRL_RUN_BIT] = fuse | run_q;
      watchdog_control_reg_o[CTRL_CLK_BIT] = ~fuse & clk_q;
      watchdog_control_reg_o[CTRL_SEL_LSB +: CTRL_SEL_W] = sel_q;
   end

   assign wdt_reset_o = (state_q == WDT_RST);
   assign irq_o = ovf_q & ~fuse;
   assign osc_start_o = (state_q == WDT_OSC);
   assign exec_hold_o = (state_q != WDT_RUN);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int A_PULSE_LAST = RST_PULSE_CYC - 1;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_fused_expire;
      fuse && expire;
   endsequence

   sequence s_pulse_body;
      wdt_reset_o [*8];
   endsequence

   property p_rc_only;
      fuse && state_q == WDT_RUN && !rc_tick && !feed_ok |=> $stable(cnt_q);
   endproperty
   a_rc_only: assert property (p_rc_only)
      else $error("fused counter moved without RC tick");

   property p_timeout_reset;
      s_fused_expire |=> s_pulse_body;
   endproperty
   a_timeout_reset: assert property (p_timeout_reset)
      else $error("fused timeout did not raise reset");

   property p_no_stop;
      running && rc_tick && fuse && !feed_ok |=> cnt_q != $past(cnt_q);
   endproperty
   a_no_stop: assert property (p_no_stop)
      else $error("fused watchdog reads as stopped");

   property p_interval;
      !fuse && expire |=> !wdt_reset_o && irq_o && cnt_q == $past(load_val);
   endproperty
   a_interval: assert property (p_interval)
      else $error("interval expiry misbehaved");

   property p_write_once;
      fuse && written_q && ctrl_wr_i.en |=> $stable(sel_q);
   endproperty
   a_write_once: assert property (p_write_once)
      else $error("locked select changed");

   property p_feed_reload;
      feed_ok && state_q == WDT_RUN |=> cnt_q == $past(load_val) && !ovf_q;
   endproperty
   a_feed_reload: assert property (p_feed_reload)
      else $error("valid feed did not reload");

   property p_arm_kept;
      armed_q && !feed_wr_i.en && !expire |=> armed_q;
   endproperty
   a_arm_kept: assert property (p_arm_kept)
      else $error("first key lost between writes");

   property p_wrong_key;
      feed_wr_i.en && feed_wr_i.data != FEED_KEY_FIRST && !feed_ok && !expire
         |=> !armed_q && !$rose(wdt_reset_o) && !$rose(ovf_q);
   endproperty
   a_wrong_key: assert property (p_wrong_key)
      else $error("wrong key kept the arm");

   property p_pulse_len;
      $rose(wdt_reset_o) |-> ##A_PULSE_LAST wdt_reset_o ##1 !wdt_reset_o;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse length wrong");

   property p_osc_hold;
      state_q == WDT_OSC && !osc_stable_s |=> exec_hold_o && osc_start_o;
   endproperty
   a_osc_hold: assert property (p_osc_hold)
      else $error("execution released before oscillator stable");

   property p_reset_value;
      $past(sys_rst_i) |-> watchdog_control_reg_o ==
         (fuse ? CTRL_RST_FUSE_ON : CTRL_RST_FUSE_OFF);
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("control register reset value wrong");

endmodule // wdt_feed_top

// ---- design/wdt_pkg.sv ----
// Watchdog feed timer shared constants and types
package wdt_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_PULSE_CYC =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Control register layout and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_OVF_BIT = 5;
   localparam int CTRL_RUN_BIT = 4;
   localparam int CTRL_CLK_BIT = 3;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_SEL_W = 3;
   localparam logic [7:0] CTRL_RST_FUSE_ON = 8'h10;
   localparam logic [7:0] CTRL_RST_FUSE_OFF = 8'h00;
   localparam logic [2:0] SEL_RST = 3'h0;

   // ----------------------------------------------------------------
   // Feed keys
   // ----------------------------------------------------------------
   localparam logic [7:0] FEED_KEY_FIRST = 8'h1e;
   localparam logic [7:0] FEED_KEY_SECOND = 8'he1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [7:0] data;
   } wdt_wr_t;

   typedef enum logic [2:0] {
      WDT_RUN = 3'b001,
      WDT_RST = 3'b010,
      WDT_OSC = 3'b100
   } wdt_state_t;

endpackage

// ---- design/wdt_tick_sync.sv ----
// Two-flop synchroniser with rising edge pulse
`timescale 1ns/1ns
module wdt_tick_sync (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Asynchronous input
   input wire logic async_i,
   // Synchronised outputs
   output logic level_o,
   output logic rise_o
);

   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   // Edge taken from sync_q and last_q only, never from meta_q
   assign level_o = sync_q;
   assign rise_o = sync_q & ~last_q;

endmodule // wdt_tick_sync

// ---- bench/tb.sv ----
// Self-checking bench for the watchdog feed timer
`timescale 1ns/1ns
module tb;
   import wdt_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [23:0] BASE = 24'h000004;
   typedef struct {
      logic [2:0] sel;
      int ticks;
   } wdt_row_t;
   wdt_row_t rows [8] = '{'{3'h0, 5}, '{3'h1, 9}, '{3'h2, 17},
      '{3'h3, 33}, '{3'h4, 65}, '{3'h5, 129}, '{3'h6, 257}, '{3'h7, 513}};
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic fuse = 1'b1;
   logic rc_zero = 1'b0;
   logic power_down_i = 1'b0;
   logic osc_stable_i = 1'b0;
   wdt_wr_t ctrl_wr = '0;
   wdt_wr_t feed_wr = '0;
   logic [7:0] reg_o;
   logic rst_o, irq_o, osc_start_o, exec_hold_o;
   logic [3:0] rc_cnt = '0;
   int fail_count = 0;
   int n_compared = 0;
   int base = 0;
   int n;
   int m;

   always #2 mclk_i = ~mclk_i;
   // RC phase restarts at reset release so timeouts repeat to the cycle
   // Sampled on the edge, applied 1 ns later, so no race with the tasks
   always @(posedge mclk_i) begin
      rc_cnt <= #1 (rc_zero ? 4'h0 : rc_cnt + 4'h1);
   end

   wdt_feed_top #(.CNT_W(24), .TICK_BASE(BASE)) dut_u (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .watchdog_enable_fuse_i(fuse), .rc_osc_i(rc_cnt[2]),
      .power_down_i(power_down_i), .osc_stable_i(osc_stable_i),
      .ctrl_wr_i(ctrl_wr), .feed_wr_i(feed_wr),
      .watchdog_control_reg_o(reg_o), .wdt_reset_o(rst_o),
      .irq_o(irq_o), .osc_start_o(osc_start_o), .exec_hold_o(exec_hold_o));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic rst(input logic f, input int hold);
      int seen;
      seen = 0;
      fuse = f;
      sys_rst_i = 1'b1;
      repeat (hold - 1) begin
         tick(1);
         if (rst_o !== 1'b0) seen++;
      end
      rc_zero = 1'b1;
      tick(1);
      rc_zero = 1'b0;
      sys_rst_i = 1'b0;
      chk("reset quiet", 0, seen);
   endtask

   // Strobe dropped for a full cycle, so writes never abut
   task automatic wr(input logic is_feed, input logic [7:0] d);
      if (is_feed) feed_wr = '{en: 1'b1, data: d};
      else ctrl_wr = '{en: 1'b1, data: d};
      tick(1);
      feed_wr = '0;
      ctrl_wr = '0;
      tick(1);
   endtask

   task automatic feed();
      wr(1'b1, FEED_KEY_FIRST);
      wr(1'b1, FEED_KEY_SECOND);
   endtask

   task automatic wait_rst(output int c);
      c = 0;
      while (rst_o !== 1'b1 && c < 6000) begin
         tick(1);
         c++;
      end
      chk("timeout seen", 1, rst_o);
   endtask

   task automatic prefix(input logic [2:0] s);
      rst(1'b1, 8);
      feed();
      wr(1'b0, {5'h0, s});
      wr(1'b0, {5'h0, ~s});
      chk("ctrl", {24'h0, CTRL_RST_FUSE_ON | {5'h0, s}}, reg_o);
      feed();
   endtask

   task automatic close_out();
      $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge mclk_i);
      fail_count++;
      close_out();
   end

   initial begin
      rst(1'b0, 8);
      chk("reg unfused", 8'h00, reg_o);
      rst(1'b1, 8);
      chk("reg fused", 8'h10, reg_o);
      chk("outs", 0, {rst_o, irq_o, osc_start_o, exec_hold_o});
      foreach (rows[i]) begin
         prefix(rows[i].sel);
         wait_rst(n);
         if (i == 0) base = n;
         chk("period", (rows[i].ticks - 5) * 8, n - base);
         m = 0;
         while (rst_o === 1'b1 && exec_hold_o === 1'b1 && m < 400) begin
            tick(1);
            m++;
         end
         chk("pulse", RST_PULSE_CYC, m);
         chk("run ovf", 2'b11, reg_o[5:4]);
         chk("no irq", 0, irq_o);
      end
      // Broken sequence must not move the deadline
      prefix(3'h0);
      wr(1'b1, 8'h1e);
      wr(1'b1, 8'h55);
      wr(1'b1, 8'he1);
      wait_rst(n);
      chk("wrong feed", base - 6, n);
      // Keys split by other traffic still reload
      prefix(3'h0);
      wr(1'b1, 8'h1e);
      wr(1'b0, 8'h03);
      tick(26);
      wr(1'b1, 8'he1);
      chk("locked ctrl", 8'h10, reg_o);
      wait_rst(n);
      chk("split feed", base, n);
      // Long foreign reset keeps counter idle
      rst(1'b1, 100);
      wait_rst(n);
      chk("idle reset", base + 4, n);
      // Timeout in power down waits for the oscillator
      prefix(3'h0);
      power_down_i = 1'b1;
      wait_rst(n);
      tick(RST_PULSE_CYC + 2);
      chk("osc wait", 2'b11, {osc_start_o, exec_hold_o});
      osc_stable_i = 1'b1;
      power_down_i = 1'b0;
      tick(6);
      chk("resume", 2'b00, {osc_start_o, exec_hold_o});
      osc_stable_i = 1'b0;
      // Interval mode raises an interrupt only
      rst(1'b0, 8);
      wr(1'b0, 8'h18);
      m = 0;
      while (irq_o !== 1'b1 && m < 300) begin
         tick(1);
         m++;
      end
      chk("irq", 1, irq_o);
      chk("no reset", 0, rst_o);
      chk("ovf flag", 1, reg_o[5]);
      wr(1'b0, 8'h08);
      chk("irq clear", 0, irq_o);
      // CPU clock source: one tick per divider wrap, far slower than RC
      wr(1'b0, 8'h10);
      feed();
      m = 0;
      while (irq_o !== 1'b1 && m < 2000) begin
         tick(1);
         m++;
      end
      chk("cpu tick", 1, irq_o === 1'b1 && m >= 1000 && m <= 1260);
      close_out();
   end
endmodule // tb
